// ---- logic/ccd_converter_command_decoder.sv ----
// Serial instruction decoder, pin gating and status word of the converter
// Function
// RULE1: Instruction is address bits DI0-DI3 then mode field DI4-DI7.
// RULE2: Codes LLLL, LLLH, LLHL convert and set next word MSB first.
// RULE3: Codes LHLL, LHLH, LHHL convert and set next word LSB first.
// RULE4: Address low with LLHH converts full scale, 12/13 bits MSB first.
// RULE5: Address low with LHHH converts offset, 12/13 bits LSB first.
// RULE6: Address low HLLL..HHLL: calibrate, auto-zero, up, down, read status.
// RULE7: HHLH sets sign off or on by DI0, starts nothing.
// RULE8: HHHL sets acquisition 6, 10, 18 or 34 core clocks by DI0, DI1.
// RULE9: HHHH selects user mode, or test mode driving analog lines if DI0.
// RULE10: Reset gives 10-cycle acquisition, sign on, 12/13 MSB, user mode.
// RULE11: Convert-inhibit high with select low only shifts out, no conversion.
// RULE12: Execute only with all pins low; power-off pin forces power down.
// RULE13: Status bits 0..2 show wake, sleep and calibration in progress.
// RULE14: Status bit 6 shows sign included in output word.
// RULE15: Status bit 7 shows results shifted out MSB first.
// RULE16: Status bits 3..5 one-hot word length; bit 8 shows test mode.
// RULE17: With select held low a frame is exactly the word length clocks.
// RULE18: Conversion result goes out during the next instruction exchange.
// RULE19: Select falling during a conversion ends it early.
`timescale 1ns/1ns
`include "ccd_map.svh"

module ccd_converter_command_decoder
  import ccd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic shiftClk,
  input wire logic serial_instruction_in,
  input wire logic convertInhibit,
  input wire logic power_off_pin,
  input wire logic [16:0] resultWord,
  input wire logic wake_busy,
  input wire logic sleepBusy,
  input wire logic calBusy,
  input wire logic convBusy,
  output logic serialDataOut,
  output ccd_core_cmd_type coreCmd,
  output logic [5:0] acqCycles,
  output logic powerDown,
  output logic [8:0] converterStatusWord,
  output logic [6:0] analog_input_lines_out,
  output logic [6:0] analog_input_lines_oe
);

  // Pin order in the synchroniser: cs, clk, data, inhibit, power-off
  logic [4:0] pinMeta_reg;
  logic [4:0] pinSync_reg;
  logic [4:0] pinPrev_reg;
  logic [4:0] bitCnt_reg;
  logic [7:0] instr_reg;
  logic [16:0] outWord_reg;
  ccd_format_type fmt_reg;
  logic [1:0] acqSel_reg;
  logic testMode_reg;
  logic sendStatus_reg;
  logic sleepReq_reg;
  logic serialDataOut_reg;
  ccd_core_cmd_type coreCmd_reg;
  logic [8:0] statusWord_reg;

  wire csLow = ~pinSync_reg[0];
  wire sclkRise = pinSync_reg[1] & ~pinPrev_reg[1];
  wire sclkFall = ~pinSync_reg[1] & pinPrev_reg[1];
  wire csFall = ~pinSync_reg[0] & pinPrev_reg[0];
  wire csRise = pinSync_reg[0] & ~pinPrev_reg[0];
  wire inhibitPin = pinSync_reg[3];
  wire offPin = pinSync_reg[4];

  // RULE17: expected clocks per exchange
  wire [4:0] baseLen = (fmt_reg.wordLen == CCD_LEN_8) ? `CCD_LEN8 :
                       (fmt_reg.wordLen == CCD_LEN_16) ? `CCD_LEN16 :
                       `CCD_LEN12;
  wire [4:0] expLen = baseLen + {4'h0, fmt_reg.signOn};

  // Instruction bit i holds DIi; DI0 arrives first
  wire [7:0] instrNow = sclkRise && bitCnt_reg < `CCD_INSTR_BITS ?
    (instr_reg | ({7'h00, pinSync_reg[2]} << bitCnt_reg[2:0])) : instr_reg;
  // RULE1: mode field and address field
  wire [3:0] mode = {instrNow[4], instrNow[5], instrNow[6], instrNow[7]};
  wire [3:0] addr = instrNow[3:0];
  wire addrLow = (addr == 4'h0);

  wire fullWord = sclkRise & csLow & (bitCnt_reg == expLen - 5'h01);
  wire csEnd = csRise & (bitCnt_reg >= `CCD_INSTR_BITS);
  wire frameEnd = fullWord | csEnd;
  // RULE11: inhibit turns the exchange into a read only
  // RULE12: instructions run only with all control pins low
  wire execute = frameEnd & ~inhibitPin & ~offPin;

  wire isConvAny = (mode[3] == 1'b0) && (mode[1:0] != 2'b11);
  wire isConvRef = (mode == `CCD_MODE_FULLSCALE ||
                    mode == `CCD_MODE_OFFSET) && addrLow;
  wire doConv = execute & (isConvAny | isConvRef);
  wire doCtl = execute & addrLow;
  wire doStatus = doCtl & (mode == `CCD_MODE_STATUS);

  // RULE2: low mode bit two clear means MSB first
  // RULE3: mode bit two set means LSB first
  ccd_format_type convFmt;
  assign convFmt.msbFirst = ~mode[2];
  assign convFmt.signOn = fmt_reg.signOn;
  // RULE4: full scale gives 12/13 MSB first
  // RULE5: offset gives 12/13 LSB first
  assign convFmt.wordLen = isConvRef ? CCD_LEN_12 :
                           (mode[1:0] == 2'b01) ? CCD_LEN_16 :
                           (mode[1:0] == 2'b10) ? CCD_LEN_8 : CCD_LEN_12;
  wire ccd_conv_type convKind = (mode == `CCD_MODE_FULLSCALE) ?
    CCD_CONV_FULLSCALE : (mode == `CCD_MODE_OFFSET) ? CCD_CONV_OFFSET :
    (mode[1:0] == 2'b10) ? CCD_CONV_8 : CCD_CONV_12;

  // RULE7: sign command only touches the sign bit
  wire doSign = execute & (mode == `CCD_MODE_SIGN) & (addr[3:1] == 3'h0);
  // RULE8: acquisition select from DI0, DI1
  wire doAcq = execute & (mode == `CCD_MODE_ACQ) & (addr[3:2] == 2'h0);
  // RULE9: test mode ignores DI1-DI3, user mode needs them low
  wire doUserTest = execute & (mode == `CCD_MODE_USER_TEST) &
                    (addr[0] | addrLow);

  // Status travels in the next exchange when asked for
  wire sendStatusNext = execute ? doStatus : sendStatus_reg;
  // RULE18: the word loaded at exchange start is the last result, or the status word when status was asked for
  wire loadWord = csFall | fullWord;
  wire [16:0] wordNext = sendStatusNext ? {8'h00, statusWord_reg} :
                         resultWord;
  wire [4:0] bitIdx = fmt_reg.msbFirst ?
    expLen - 5'h01 - bitCnt_reg : bitCnt_reg;
  wire outBit = (bitIdx < 5'h11) ? outWord_reg[bitIdx] : 1'b0;
  wire firstBit = fmt_reg.msbFirst ? wordNext[expLen - 5'h01] : wordNext[0];

  logic [5:0] acqNext;
  always_comb begin
    unique case (acqSel_reg)
      2'h0: acqNext = `CCD_ACQ_LL;
      2'h1: acqNext = `CCD_ACQ_LH;
      2'h2: acqNext = `CCD_ACQ_HL;
      2'h3: acqNext = `CCD_ACQ_HH;
    endcase
  end

  // Two stages before any pin is looked at
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinMeta_reg <= 5'h01;
      pinSync_reg <= 5'h01;
      pinPrev_reg <= 5'h01;
    end else begin
      pinMeta_reg <= {power_off_pin, convertInhibit, serial_instruction_in,
                      shiftClk, chipSelectN};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // Frame bit counter and instruction capture
  always_ff @(posedge ref_clk) begin
    if (rst || !csLow || frameEnd) begin
      bitCnt_reg <= 5'h00;
      instr_reg <= 8'h00;
    end else if (sclkRise) begin
      bitCnt_reg <= bitCnt_reg + 5'h01;
      instr_reg <= instrNow;
    end
  end

  // Output word and serial data; falling edges move to the next bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      outWord_reg <= 17'h00000;
      serialDataOut_reg <= 1'b0;
    end else if (loadWord) begin
      outWord_reg <= wordNext;
      serialDataOut_reg <= firstBit;
    end else if (sclkFall && csLow) begin
      serialDataOut_reg <= outBit;
    end
  end

  // Configuration; RULE10: defaults after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fmt_reg <= '{CCD_LEN_12, `CCD_RST_MSB, `CCD_RST_SIGN};
      acqSel_reg <= `CCD_RST_ACQ;
      testMode_reg <= 1'b0;
      sendStatus_reg <= 1'b0;
      sleepReq_reg <= 1'b0;
    end else begin
      if (doConv) begin
        fmt_reg <= convFmt;
      end else if (doSign) begin
        fmt_reg.signOn <= addr[0];
      end
      if (doAcq) begin
        // DI0 is the upper select bit: DI0 low, DI1 high gives 10 cycles
        acqSel_reg <= {addr[0], addr[1]};
      end
      if (doUserTest) begin
        testMode_reg <= addr[0];
      end
      if (execute) begin
        sendStatus_reg <= doStatus;
      end
      // RULE6: power commands steer only the power state
      if (doCtl && mode == `CCD_MODE_POWER_UP) begin
        sleepReq_reg <= 1'b0;
      end else if (doCtl && mode == `CCD_MODE_POWER_DOWN) begin
        sleepReq_reg <= 1'b1;
      end
    end
  end

  // Core commands are one-cycle pulses; address and kind are held
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coreCmd_reg <= '0;
    end else begin
      coreCmd_reg.convStart <= doConv;
      if (doConv) begin
        coreCmd_reg.convKind <= convKind;
        coreCmd_reg.muxAddr <= addr;
      end
      // RULE6: calibration and auto-zero starts
      coreCmd_reg.calStart <= doCtl & (mode == `CCD_MODE_CAL);
      coreCmd_reg.zeroStart <= doCtl & (mode == `CCD_MODE_ZERO);
      // RULE19: select falling cuts a running conversion short
      coreCmd_reg.convAbort <= csFall & convBusy;
    end
  end

  // RULE13: device status bits
  // RULE14: sign bit
  // RULE15: justification bit
  // RULE16: one-hot length and test mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      statusWord_reg <= 9'h000;
    end else begin
      statusWord_reg[`CCD_ST_WAKE] <= wake_busy;
      statusWord_reg[`CCD_ST_SLEEP] <= sleepBusy;
      statusWord_reg[`CCD_ST_CAL] <= calBusy;
      statusWord_reg[`CCD_ST_LEN8] <= (fmt_reg.wordLen == CCD_LEN_8);
      statusWord_reg[`CCD_ST_LEN12] <= (fmt_reg.wordLen == CCD_LEN_12);
      statusWord_reg[`CCD_ST_LEN16] <= (fmt_reg.wordLen == CCD_LEN_16);
      statusWord_reg[`CCD_ST_SIGN] <= fmt_reg.signOn;
      statusWord_reg[`CCD_ST_MSB] <= fmt_reg.msbFirst;
      statusWord_reg[`CCD_ST_TEST] <= testMode_reg;
    end
  end

  // Registered pin-level outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acqCycles <= `CCD_ACQ_LH;
      powerDown <= 1'b0;
      analog_input_lines_out <= 7'h00;
      analog_input_lines_oe <= 7'h00;
    end else begin
      acqCycles <= acqNext;
      // RULE12: power-off pin wins over everything
      powerDown <= offPin | sleepReq_reg;
      // RULE9: test mode turns the analog lines into outputs
      analog_input_lines_out <= statusWord_reg[6:0];
      analog_input_lines_oe <= {7{testMode_reg}};
    end
  end

  assign serialDataOut = serialDataOut_reg;
  assign coreCmd = coreCmd_reg;
  assign converterStatusWord = statusWord_reg;

endmodule : ccd_converter_command_decoder

// ---- shared/ccd_map.svh ----
// Constants for the converter command decoder: codes, bit positions, resets
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// Mode field codes, written {DI4,DI5,DI6,DI7}
`define CCD_MODE_C12_MSB 4'h0
`define CCD_MODE_C16_MSB 4'h1
`define CCD_MODE_C8_MSB 4'h2
`define CCD_MODE_FULLSCALE 4'h3
`define CCD_MODE_C12_LSB 4'h4
`define CCD_MODE_C16_LSB 4'h5
`define CCD_MODE_C8_LSB 4'h6
`define CCD_MODE_OFFSET 4'h7
`define CCD_MODE_CAL 4'h8
`define CCD_MODE_ZERO 4'h9
`define CCD_MODE_POWER_UP 4'hA
`define CCD_MODE_POWER_DOWN 4'hB
`define CCD_MODE_STATUS 4'hC
`define CCD_MODE_SIGN 4'hD
`define CCD_MODE_ACQ 4'hE
`define CCD_MODE_USER_TEST 4'hF

// Instruction length and word lengths without sign
`define CCD_INSTR_BITS 5'h08
`define CCD_LEN8 5'h08
`define CCD_LEN12 5'h0C
`define CCD_LEN16 5'h10

// Acquisition times in analog core clock cycles
`define CCD_ACQ_LL 6'h06
`define CCD_ACQ_LH 6'h0A
`define CCD_ACQ_HL 6'h12
`define CCD_ACQ_HH 6'h22

// Status word bit positions
`define CCD_ST_WAKE 0
`define CCD_ST_SLEEP 1
`define CCD_ST_CAL 2
`define CCD_ST_LEN8 3
`define CCD_ST_LEN12 4
`define CCD_ST_LEN16 5
`define CCD_ST_SIGN 6
`define CCD_ST_MSB 7
`define CCD_ST_TEST 8

// Reset values
`define CCD_RST_ACQ 2'h1
`define CCD_RST_SIGN 1'h1
`define CCD_RST_MSB 1'h1

`endif

// ---- shared/ccd_pkg.sv ----
// Types shared by the converter command decoder and its bench
package ccd_pkg;

  typedef enum logic [1:0] {
    CCD_LEN_8 = 2'b00,
    CCD_LEN_12 = 2'b01,
    CCD_LEN_16 = 2'b10
  } ccd_len_type;

  typedef enum logic [1:0] {
    CCD_CONV_12 = 2'b00,
    CCD_CONV_8 = 2'b01,
    CCD_CONV_FULLSCALE = 2'b10,
    CCD_CONV_OFFSET = 2'b11
  } ccd_conv_type;

  // Output word format for the next exchange
  typedef struct packed {
    ccd_len_type wordLen;
    logic msbFirst;
    logic signOn;
  } ccd_format_type;

  // Commands handed to the analog core
  typedef struct packed {
    logic convStart;
    ccd_conv_type convKind;
    logic [3:0] muxAddr;
    logic calStart;
    logic zeroStart;
    logic convAbort;
  } ccd_core_cmd_type;

endpackage : ccd_pkg

// ---- test/ccd_dec_properties.sv ----
// Port assertions for the converter command decoder
`timescale 1ns/1ns
module ccd_dec_checker
  import ccd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic convertInhibit,
  input wire logic power_off_pin,
  input wire logic wake_busy,
  input wire logic convBusy,
  input wire ccd_core_cmd_type coreCmd,
  input wire logic [5:0] acqCycles,
  input wire logic powerDown,
  input wire logic [8:0] converterStatusWord,
  input wire logic [6:0] analog_input_lines_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst_st; $fell(rst) |-> acqCycles == 6'h0A && !powerDown;
  endproperty
  a_rst_st: assert property (p_rst_st) else $error("reset state");
  property p_len; !$past(rst, 3) |-> $onehot(converterStatusWord[5:3]);
  endproperty
  a_len: assert property (p_len) else $error("length flags");
  property p_wake; $rose(wake_busy) |-> ##[1:3] converterStatusWord[0];
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag");
  property p_oe; analog_input_lines_oe inside {7'h00, 7'h7F}; endproperty
  a_oe: assert property (p_oe) else $error("line enables");
  property p_test;
    $rose(&analog_input_lines_oe) |-> ##[0:2] converterStatusWord[8];
  endproperty
  a_test: assert property (p_test) else $error("test flag");
  property p_acq; acqCycles inside {6'h06, 6'h0A, 6'h12, 6'h22}; endproperty
  a_acq: assert property (p_acq) else $error("acquisition");
  property p_gate;
    coreCmd.convStart |-> !convertInhibit && !power_off_pin;
  endproperty
  a_gate: assert property (p_gate) else $error("gated start");
  property p_pd; power_off_pin [*4] |=> powerDown; endproperty
  a_pd: assert property (p_pd) else $error("pin power down");
  property p_abort; $fell(chipSelectN) && convBusy ##1 convBusy [*2]
    |-> ##[1:4] coreCmd.convAbort; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
endmodule : ccd_dec_checker

bind ccd_converter_command_decoder ccd_dec_checker chk_u (
  .ref_clk(ref_clk), .rst(rst), .chipSelectN(chipSelectN),
  .convertInhibit(convertInhibit), .power_off_pin(power_off_pin),
  .wake_busy(wake_busy), .convBusy(convBusy), .coreCmd(coreCmd),
  .acqCycles(acqCycles), .powerDown(powerDown),
  .converterStatusWord(converterStatusWord),
  .analog_input_lines_oe(analog_input_lines_oe)
);

// ---- test/ccd_host_model.sv ----
// Host side of the serial instruction link
`timescale 1ns/1ns
module ccd_host_model (
  input wire logic ref_clk,
  input wire logic serialDataOut,
  output logic chipSelectN,
  output logic shiftClk,
  output logic serial_instruction_in
);
  initial begin
    chipSelectN = 1'h1;
    shiftClk = 1'h0;
    serial_instruction_in = 1'h0;
  end
  task automatic half;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : half
  task automatic frame(input logic [7:0] ins, input int n,
                       output logic [16:0] rx);
    rx = 17'h00000;
    chipSelectN = 1'h0;
    for (int i = 0; i < n; i++) begin
      serial_instruction_in = (i < 8) ? ins[i] : ~serial_instruction_in;
      half;
      shiftClk = 1'h1;
      rx = {rx[15:0], serialDataOut};
      half;
      shiftClk = 1'h0;
    end
    half;
    chipSelectN = 1'h1;
    // Released line must not keep showing the last bit
    serial_instruction_in = ~serial_instruction_in;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask : frame
endmodule : ccd_host_model

// ---- test/ccd_converter_command_decoder_tb.sv ----
// Self-checking bench for the converter command decoder
`timescale 1ns/1ns
module ccd_converter_command_decoder_tb;
  import ccd_pkg::*;
  logic ref_clk, rst, chipSelectN, shiftClk, serial_instruction_in;
  logic convertInhibit, power_off_pin, wake_busy, sleepBusy, calBusy;
  logic convBusy, serialDataOut, powerDown;
  ccd_core_cmd_type coreCmd;
  logic [5:0] acqCycles;
  logic [8:0] converterStatusWord;
  logic [6:0] linesOe;
  logic [6:0] linesOut;
  logic [16:0] rx;
  int err_count = 0, checks = 0, starts = 0, aborts = 0;
  int cals = 0, zeros = 0;
  ccd_converter_command_decoder dut_u (.ref_clk(ref_clk), .rst(rst),
    .chipSelectN(chipSelectN), .shiftClk(shiftClk),
    .serial_instruction_in(serial_instruction_in),
    .convertInhibit(convertInhibit), .power_off_pin(power_off_pin),
    .resultWord(17'h1A5A5), .wake_busy(wake_busy), .sleepBusy(sleepBusy),
    .calBusy(calBusy), .convBusy(convBusy), .serialDataOut(serialDataOut),
    .coreCmd(coreCmd), .acqCycles(acqCycles), .powerDown(powerDown),
    .converterStatusWord(converterStatusWord),
    .analog_input_lines_out(linesOut), .analog_input_lines_oe(linesOe));
  ccd_host_model host_u (.ref_clk(ref_clk), .serialDataOut(serialDataOut),
    .chipSelectN(chipSelectN), .shiftClk(shiftClk),
    .serial_instruction_in(serial_instruction_in));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    starts <= starts + coreCmd.convStart;
    aborts <= aborts + coreCmd.convAbort;
    cals <= cals + coreCmd.calStart;
    zeros <= zeros + coreCmd.zeroStart;
  end
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [3:0] adr, mode);
    host_u.frame({mode[0], mode[1], mode[2], mode[3], adr}, 8, rx);
  endtask : cmd
  task automatic t_status;
    check(converterStatusWord, 9'h0D0);
    check(acqCycles, 6'h0A);
    cmd(4'h0, 4'hC);
    host_u.frame(8'h00, 13, rx);
    check(rx[12:0], 13'h00D0);
    $display("status test done");
  endtask : t_status
  task automatic t_conv;
    logic [3:0] code [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h3, 4'h7};
    logic [8:0] st [8] = '{9'h0D0, 9'h0E0, 9'h0C8, 9'h050, 9'h060, 9'h048,
      9'h0D0, 9'h050};
    logic [1:0] kind [8] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    int n;
    for (int i = 0; i < 8; i++) begin
      n = starts;
      cmd(i < 6 ? 4'h6 : 4'h0, code[i]);
      check(starts - n, 1);
      check(coreCmd.convKind, kind[i]);
      check(coreCmd.muxAddr, i < 6 ? 4'h6 : 4'h0);
      check(converterStatusWord, st[i]);
    end
    // Offset code left 12/13 LSB first: the result comes out reversed
    host_u.frame(8'h30, 13, rx);
    check(rx[12:0], 13'h14B4);
    $display("conversion test done");
  endtask : t_conv
  task automatic t_cfg;
    logic [5:0] acq [4] = '{6'h06, 6'h0A, 6'h12, 6'h22};
    int n = starts;
    cmd(4'h0, 4'hD);
    check(converterStatusWord[6], 1'h0);
    cmd(4'h1, 4'hD);
    check(converterStatusWord[6], 1'h1);
    for (int i = 0; i < 4; i++) begin
      cmd({2'h0, i[0], i[1]}, 4'hE);
      check(acqCycles, acq[i]);
    end
    cmd(4'h1, 4'hF);
    check(linesOe, 7'h7F);
    check(converterStatusWord[8], 1'h1);
    check(linesOut, 7'h50);
    cmd(4'h0, 4'hF);
    check(linesOe, 7'h00);
    cmd(4'h0, 4'hB);
    check(powerDown, 1'h1);
    cmd(4'h0, 4'hA);
    check(powerDown, 1'h0);
    cmd(4'h0, 4'h8);
    cmd(4'h0, 4'h9);
    check(cals, 1);
    check(zeros, 1);
    check(starts - n, 0);
    $display("config test done");
  endtask : t_cfg
  task automatic t_pins;
    int n = starts;
    convertInhibit = 1'h1;
    convBusy = 1'h1;
    cmd(4'h6, 4'h0);
    check(starts - n, 0);
    check(aborts > 0, 1);
    convertInhibit = 1'h0;
    convBusy = 1'h0;
    power_off_pin = 1'h1;
    cmd(4'h6, 4'h0);
    check(powerDown, 1'h1);
    check(starts - n, 0);
    power_off_pin = 1'h0;
    {wake_busy, sleepBusy, calBusy} = 3'h7;
    repeat (4) @(posedge ref_clk);
    #1;
    check(converterStatusWord[2:0], 3'h7);
    {wake_busy, sleepBusy, calBusy} = 3'h0;
    $display("pin test done");
  endtask : t_pins
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  initial begin
    rst = 1'h1;
    {convertInhibit, power_off_pin, wake_busy} = 3'h0;
    {sleepBusy, calBusy, convBusy} = 3'h0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    t_status;
    t_conv;
    t_cfg;
    t_pins;
    conclude;
  end
  initial begin
    #600000;
    err_count++;
    conclude;
  end
endmodule : ccd_converter_command_decoder_tb
